// ===== rtl/seq_pkg.sv
// shared constants, register map and state codes of the reference step sequencer
package seq_pkg;
  localparam int NUM_REFS = 16;
  localparam logic [15:0] REF_RESET = 16'h0000;
  localparam logic signed [15:0] REF_MAX = 16'sh03E8;
  localparam logic signed [15:0] REF_MIN = -16'sh03E8;
  localparam logic [15:0] DUR_RESET = 16'h0000;
  localparam logic [1:0] RAMP_RESET = 2'h0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int PCT_FULL = 1000;
  // register map: bank selects on address bits 7:6, then byte addresses
  localparam logic [1:0] REF_BANK = 2'h0;
  localparam logic [1:0] STEP_BANK = 2'h1;
  localparam logic [7:0] CTRL_OFS = 8'h80;
  localparam logic [7:0] STAT_OFS = 8'h84;
  // control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_UNIT_BIT = 2;
  localparam int CTRL_KEEP_PWR_BIT = 4;
  localparam int CTRL_KEEP_STOP_BIT = 5;
  localparam int CTRL_SRC_LSB = 8;
  localparam int CTRL_TGT_BIT = 12;
  localparam int CTRL_EN_BIT = 13;
  localparam logic [15:0] CTRL_MASK = 16'h3737;
  // step word field, then control mode and source codes and the last step index
  localparam int STEP_RAMP_LSB = 16;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h2;
  localparam logic [2:0] SRC_PRESET = 3'h0;
  localparam logic [2:0] SRC_AI1 = 3'h1;
  localparam logic [2:0] SRC_AI2 = 3'h2;
  localparam logic [2:0] SRC_AI3 = 3'h3;
  localparam logic [2:0] SRC_PULSE = 3'h4;
  localparam logic [2:0] SRC_PID = 3'h5;
  localparam logic [2:0] SRC_UPDN = 3'h6;
  localparam logic [3:0] LAST_STEP = 4'hF;
  // timing, then bus response codes and state codes
  localparam int CLK_PERIOD_NS = 10;
  localparam int TENTH_SEC_NS = 100000000;
  localparam int TENTH_SEC_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam logic [11:0] HOUR_FACTOR = 12'hE10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_HOLD = 4'h4,
    ST_PAUSE = 4'h8
  } seq_state_e;
endpackage : seq_pkg

// ===== rtl/multi_reference_step_sequencer.sv
// multi-reference table with timed step sequencer and AXI4-Lite register slave
// Functional notes
// R1: sixteen signed references, -100.0..100.0 percent in 0.1 steps, reset zero.
// R2: frequency output is reference times maximum output frequency.
// R3: voltage output scales by rated motor voltage; PID output passes unchanged.
// R4: terminal states pick the active reference when not sequencing.
// R5: mode 0 stops the drive after one cycle until a new run.
// R6: mode 1 holds last step frequency and direction after one cycle.
// R7: mode 2 restarts the cycle automatically until stop arrives.
// R8: sequencer output drives either frequency or separated voltage setpoint.
// R9: on frequency, a negative step reference means reverse direction.
// R10: power-loss retention keeps step and elapsed time across power failure.
// R11: stop retention keeps position across stop; otherwise restart at step zero.
// R12: each step has a duration 0..6553.5 in tenths, reset zero.
// R13: each step selects one of four ramp sets, reset first set.
// R14: one unit bit makes durations seconds or hours.
// R15: reference zero comes from a selectable source channel.
// R16: steps advance in ascending order; cycle completes after last step.
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
module multi_reference_step_sequencer #(
  parameter int TENTH_CYCLES = seq_pkg::TENTH_SEC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [3:0] digital_input_terminal,
  input wire logic signed [15:0] analog_input_one,
  input wire logic signed [15:0] analog_input_two,
  input wire logic signed [15:0] analog_input_three,
  input wire logic signed [15:0] pulse_input,
  input wire logic signed [15:0] pid_output,
  input wire logic signed [15:0] preset_frequency,
  input wire logic [15:0] max_frequency,
  input wire logic [15:0] rated_motor_voltage,
  input wire logic run_cmd,
  input wire logic stop_cmd,
  input wire logic power_fail,
  output logic signed [15:0] freq_setpoint,
  output logic signed [15:0] voltage_setpoint,
  output logic signed [15:0] pid_setpoint,
  output logic run_reverse,
  output logic [1:0] ramp_set_sel,
  output logic seq_running,
  output logic drive_stop_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // byte-lane merge, shared by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // percent in tenths times a base; the product is held in 34 bits before the divide
  function automatic logic signed [15:0] scale(input logic signed [15:0] pct,
                                               input logic [15:0] base);
    logic signed [33:0] prod;
    prod = 34'(pct) * $signed({18'h00000, base});
    return 16'(prod / 34'sd1000);
  endfunction : scale

  // out-of-range writes saturate so a stored reference never leaves its span
  function automatic logic signed [15:0] clamp(input logic signed [15:0] v);
    if (v > seq_pkg::REF_MAX) begin
      return seq_pkg::REF_MAX;
    end
    if (v < seq_pkg::REF_MIN) begin
      return seq_pkg::REF_MIN;
    end
    return v;
  endfunction : clamp

  logic [3:0] di_meta_ff, di_sync_ff;
  logic signed [15:0] refs_ff [16];
  logic signed [15:0] nxt_refs [16];
  logic [17:0] steps_ff [16];
  logic [17:0] nxt_steps [16];
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
  logic [7:0] waddr_ff, nxt_waddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  seq_pkg::seq_state_e state_ff, nxt_state;
  logic [3:0] step_ff, nxt_step;
  logic [15:0] elapsed_ff, nxt_elapsed;
  logic [23:0] pre_ff, nxt_pre;
  logic [11:0] hour_ff, nxt_hour;
  logic keep_ff, nxt_keep, stop_req_ff, nxt_stop_req;
  logic signed [15:0] freq_ff, volt_ff, pid_ff;
  logic rev_ff, running_ff;
  logic [1:0] ramp_ff;
  logic signed [15:0] ref0_val, active_ref;
  logic [1:0] mode;
  logic tenth_tick, unit_tick, step_done, cycle_end, seq_on, tgt_volt;
  logic [3:0] ref_idx;

  // terminal pins are asynchronous: two flops before anything reads them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      di_meta_ff <= 4'h0;
      di_sync_ff <= 4'h0;
    end else begin
      di_meta_ff <= digital_input_terminal;
      di_sync_ff <= di_meta_ff;
    end
  end

  assign awready = !aw_hold_ff;
  assign wready = !w_hold_ff;
  assign arready = !rvalid_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // bus slave: address and data latched in either order, write on both held
  always_comb begin
    nxt_refs = refs_ff;
    nxt_steps = steps_ff;
    nxt_ctrl = ctrl_ff;
    nxt_aw_hold = aw_hold_ff;
    nxt_waddr = waddr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    if (awvalid && awready) begin
      nxt_aw_hold = 1'b1;
      nxt_waddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = wdata;
      nxt_wstrb = wstrb;
    end
    if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = seq_pkg::RESP_OKAY;
      if (waddr_ff[7:6] == seq_pkg::REF_BANK) begin
        nxt_refs[waddr_ff[5:2]] = clamp(16'(merge({16'h0000, refs_ff[waddr_ff[5:2]]},
                                   wdata_ff, wstrb_ff))); // [R1]
      end else if (waddr_ff[7:6] == seq_pkg::STEP_BANK) begin
        nxt_steps[waddr_ff[5:2]] = 18'(merge({14'h0000, steps_ff[waddr_ff[5:2]]},
                                   wdata_ff, wstrb_ff)); // [R12] [R13]
      end else if (waddr_ff == seq_pkg::CTRL_OFS) begin
        nxt_ctrl = 16'(merge({16'h0000, ctrl_ff}, wdata_ff, wstrb_ff)) & seq_pkg::CTRL_MASK;
      end else begin
        nxt_bresp = seq_pkg::RESP_SLVERR; // status is read-only, rest unmapped
      end
    end
    if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = seq_pkg::RESP_OKAY;
      if (araddr[7:6] == seq_pkg::REF_BANK) begin
        nxt_rdata = {{16{refs_ff[araddr[5:2]][15]}}, refs_ff[araddr[5:2]]};
      end else if (araddr[7:6] == seq_pkg::STEP_BANK) begin
        nxt_rdata = {14'h0000, steps_ff[araddr[5:2]]};
      end else if (araddr == seq_pkg::CTRL_OFS) begin
        nxt_rdata = {16'h0000, ctrl_ff};
      end else if (araddr == seq_pkg::STAT_OFS) begin
        nxt_rdata = {elapsed_ff, 7'h00, rev_ff, state_ff, step_ff};
      end else begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = seq_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < seq_pkg::NUM_REFS; i++) begin
        refs_ff[i] <= seq_pkg::REF_RESET; // [R1]
        steps_ff[i] <= {seq_pkg::RAMP_RESET, seq_pkg::DUR_RESET}; // [R12] [R13]
      end
      ctrl_ff <= seq_pkg::CTRL_RESET;
      aw_hold_ff <= 1'b0;
      waddr_ff <= 8'h00;
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end else begin
      refs_ff <= nxt_refs;
      steps_ff <= nxt_steps;
      ctrl_ff <= nxt_ctrl;
      aw_hold_ff <= nxt_aw_hold;
      waddr_ff <= nxt_waddr;
      w_hold_ff <= nxt_w_hold;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // time base: tenth-second prescaler, hour mode counts 3600 of them per tenth
  assign mode = ctrl_ff[seq_pkg::CTRL_MODE_LSB +: 2];
  assign tgt_volt = ctrl_ff[seq_pkg::CTRL_TGT_BIT];
  assign tenth_tick = (pre_ff == 24'(TENTH_CYCLES - 1));
  assign unit_tick = tenth_tick && (!ctrl_ff[seq_pkg::CTRL_UNIT_BIT] ||
                     hour_ff == seq_pkg::HOUR_FACTOR - 12'h001); // [R14]
  assign step_done = (elapsed_ff >= steps_ff[step_ff][15:0]); // [R12]
  assign cycle_end = (state_ff == seq_pkg::ST_RUN) && step_done &&
                     (step_ff == seq_pkg::LAST_STEP); // [R16]

  // sequencer: zero duration steps are skipped after one cycle each
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_elapsed = elapsed_ff;
    nxt_pre = pre_ff;
    nxt_hour = hour_ff;
    nxt_keep = keep_ff;
    nxt_stop_req = 1'b0;
    case (state_ff)
      seq_pkg::ST_IDLE: begin
        if (run_cmd && ctrl_ff[seq_pkg::CTRL_EN_BIT]) begin
          nxt_state = seq_pkg::ST_RUN;
          nxt_keep = 1'b0;
          if (!keep_ff) begin
            nxt_step = 4'h0; // [R11]
            nxt_elapsed = 16'h0000;
            nxt_pre = 24'h000000;
            nxt_hour = 12'h000;
          end
        end
      end
      seq_pkg::ST_RUN: begin
        if (stop_cmd) begin
          nxt_state = seq_pkg::ST_IDLE;
          nxt_keep = ctrl_ff[seq_pkg::CTRL_KEEP_STOP_BIT]; // [R11]
        end else if (power_fail) begin
          nxt_state = seq_pkg::ST_PAUSE; // [R10]
        end else if (step_done) begin
          nxt_elapsed = 16'h0000;
          nxt_pre = 24'h000000;
          nxt_hour = 12'h000;
          if (step_ff != seq_pkg::LAST_STEP) begin
            nxt_step = step_ff + 4'h1; // [R16]
          end else if (mode == seq_pkg::MODE_HOLD) begin
            nxt_state = seq_pkg::ST_HOLD; // [R6]
          end else if (mode == seq_pkg::MODE_REPEAT) begin
            nxt_step = 4'h0; // [R7]
          end else begin
            nxt_state = seq_pkg::ST_IDLE; // [R5]
            nxt_stop_req = 1'b1;
            nxt_step = 4'h0;
          end
        end else begin
          nxt_pre = tenth_tick ? 24'h000000 : pre_ff + 24'h000001;
          if (tenth_tick) begin
            nxt_hour = unit_tick ? 12'h000 : hour_ff + 12'h001;
          end
          if (unit_tick) begin
            nxt_elapsed = elapsed_ff + 16'h0001;
          end
        end
      end
      seq_pkg::ST_HOLD: begin
        if (stop_cmd) begin
          nxt_state = seq_pkg::ST_IDLE;
          nxt_step = 4'h0;
        end
      end
      seq_pkg::ST_PAUSE: begin
        if (stop_cmd) begin
          nxt_state = seq_pkg::ST_IDLE;
          nxt_keep = ctrl_ff[seq_pkg::CTRL_KEEP_STOP_BIT];
        end else if (!power_fail) begin
          nxt_state = seq_pkg::ST_RUN;
          if (!ctrl_ff[seq_pkg::CTRL_KEEP_PWR_BIT]) begin
            nxt_step = 4'h0; // [R10]
            nxt_elapsed = 16'h0000;
            nxt_pre = 24'h000000;
            nxt_hour = 12'h000;
          end
        end
      end
      default: begin
        nxt_state = seq_pkg::ST_IDLE;
        nxt_step = 4'h0;
      end
    endcase
    if ((state_ff == seq_pkg::ST_IDLE) && !nxt_keep && !run_cmd) begin
      nxt_step = 4'h0; // [R11] restart point once position is not retained
      nxt_elapsed = 16'h0000;
    end
  end

  // reference selection: sequencer step while active, terminals otherwise
  assign seq_on = (state_ff != seq_pkg::ST_IDLE);
  assign ref_idx = seq_on ? step_ff : di_sync_ff; // [R4]
  always_comb begin
    case (ctrl_ff[seq_pkg::CTRL_SRC_LSB +: 3]) // [R15]
      seq_pkg::SRC_PRESET: ref0_val = refs_ff[0];
      seq_pkg::SRC_AI1: ref0_val = analog_input_one;
      seq_pkg::SRC_AI2: ref0_val = analog_input_two;
      seq_pkg::SRC_AI3: ref0_val = analog_input_three;
      seq_pkg::SRC_PULSE: ref0_val = pulse_input;
      seq_pkg::SRC_PID: ref0_val = pid_output;
      seq_pkg::SRC_UPDN: ref0_val = preset_frequency;
      default: ref0_val = refs_ff[0];
    endcase
    active_ref = (ref_idx == 4'h0) ? ref0_val : refs_ff[ref_idx];
  end

  // registered setpoints; the idle sequencer target drives nothing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= seq_pkg::ST_IDLE;
      step_ff <= 4'h0;
      elapsed_ff <= 16'h0000;
      pre_ff <= 24'h000000;
      hour_ff <= 12'h000;
      keep_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      freq_ff <= 16'sh0000;
      volt_ff <= 16'sh0000;
      pid_ff <= 16'sh0000;
      rev_ff <= 1'b0;
      ramp_ff <= 2'h0;
      running_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      elapsed_ff <= nxt_elapsed;
      pre_ff <= nxt_pre;
      hour_ff <= nxt_hour;
      keep_ff <= nxt_keep;
      stop_req_ff <= nxt_stop_req;
      freq_ff <= (seq_on && tgt_volt) ? 16'sh0000 : scale(active_ref, max_frequency); // [R2] [R8]
      volt_ff <= (seq_on && !tgt_volt) ? 16'sh0000 :
                 scale(active_ref, rated_motor_voltage); // [R3] [R8]
      pid_ff <= active_ref; // [R3]
      rev_ff <= seq_on && !tgt_volt && active_ref[15]; // [R9]
      ramp_ff <= seq_on ? steps_ff[step_ff][seq_pkg::STEP_RAMP_LSB +: 2] : 2'h0; // [R13]
      running_ff <= seq_on;
    end
  end

  assign freq_setpoint = freq_ff;
  assign voltage_setpoint = volt_ff;
  assign pid_setpoint = pid_ff;
  assign run_reverse = rev_ff;
  assign ramp_set_sel = ramp_ff;
  assign seq_running = running_ff;
  assign drive_stop_req = stop_req_ff;

  chk_mode0_stop: assert property (cycle_end && !stop_cmd && !power_fail && mode == 2'h0 // [R5]
    |=> state_ff == seq_pkg::ST_IDLE && drive_stop_req ##1 !drive_stop_req)
    else $error("mode 0 did not stop after one cycle");
  chk_mode1_hold: assert property (cycle_end && !stop_cmd && !power_fail && mode == 2'h1 // [R6]
    |=> state_ff == seq_pkg::ST_HOLD && step_ff == 4'hF)
    else $error("mode 1 did not hold the last step");
  chk_mode2_wrap: assert property (cycle_end && !stop_cmd && !power_fail && mode == 2'h2 // [R7]
    |=> state_ff == seq_pkg::ST_RUN && step_ff == 4'h0)
    else $error("mode 2 did not restart the cycle");
  chk_step_order: assert property (state_ff == seq_pkg::ST_RUN && step_done && !stop_cmd // [R16]
    && !power_fail && step_ff != 4'hF |=> step_ff == $past(step_ff) + 4'h1)
    else $error("step did not advance by one");
  chk_dir_sign: assert property (seq_on && !tgt_volt // [R9]
    |=> run_reverse == $past(active_ref[15]))
    else $error("direction does not follow reference sign");
  chk_pid_pass: assert property (##1 pid_setpoint == $past(active_ref)) // [R3]
    else $error("pid setpoint altered");
  chk_stop_restart: assert property (state_ff == seq_pkg::ST_RUN && stop_cmd && // [R11]
    !ctrl_ff[seq_pkg::CTRL_KEEP_STOP_BIT] ##1 !run_cmd |=> step_ff == 4'h0)
    else $error("stop without retention kept the position");
  chk_hold_steady: assert property (state_ff == seq_pkg::ST_HOLD && !stop_cmd // [R6]
    |=> state_ff == seq_pkg::ST_HOLD && $stable(step_ff))
    else $error("hold state left without stop");
  cov_repeat: cover property (cycle_end && mode == 2'h2);
  cov_resume: cover property (state_ff == seq_pkg::ST_PAUSE ##1 state_ff == seq_pkg::ST_RUN);
  cov_reverse: cover property (seq_running && run_reverse);
endmodule : multi_reference_step_sequencer

// ===== verif/setpoint_loop_model.sv
// far-side model: setpoint loop that logs every new setpoint and each stop request
module setpoint_loop_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic signed [15:0] freq_setpoint,
  input wire logic run_reverse,
  input wire logic [1:0] ramp_set_sel,
  input wire logic drive_stop_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] seen_f[$];
  logic seen_rev[$];
  logic [1:0] seen_ramp[$];
  int seen_at[$];
  int cyc;
  int stops;
  logic signed [15:0] last_f;
  // a real loop only reacts to a new setpoint, so changes are logged with their cycle;
  // sampling on the falling edge sees settled setpoints and never races the bench
  always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc = 0;
      stops = 0;
      last_f = 16'h0000;
    end else begin
      cyc++;
      if (drive_stop_req === 1'b1) begin
        stops++;
      end
      if (freq_setpoint !== last_f) begin
        seen_f.push_back(freq_setpoint);
        seen_rev.push_back(run_reverse);
        seen_ramp.push_back(ramp_set_sel);
        seen_at.push_back(cyc);
        last_f = freq_setpoint;
      end
    end
  end
endmodule : setpoint_loop_model

// ===== verif/multi_reference_step_sequencer_test.sv
// self-checking bench of the reference step sequencer
module multi_reference_step_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, run_cmd = 1'b0, stop_cmd = 1'b0, power_fail = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, run_reverse, seq_running, drive_stop_req;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF, terms = 4'h0;
  logic [1:0] bresp, rresp, ramp_set_sel;
  logic signed [15:0] ai1 = '0, ai2 = '0, ai3 = '0, pulse = '0, pidin = '0, preset = '0;
  logic signed [15:0] freq, volt, pid_sp;
  logic [15:0] maxf = 16'h03E8, rated = 16'h01F4;
  int bad_count, samples_checked, base;

  multi_reference_step_sequencer #(.TENTH_CYCLES(4)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .digital_input_terminal(terms),
    .analog_input_one(ai1), .analog_input_two(ai2), .analog_input_three(ai3),
    .pulse_input(pulse), .pid_output(pidin), .preset_frequency(preset),
    .max_frequency(maxf), .rated_motor_voltage(rated), .run_cmd(run_cmd),
    .stop_cmd(stop_cmd), .power_fail(power_fail), .freq_setpoint(freq),
    .voltage_setpoint(volt), .pid_setpoint(pid_sp), .run_reverse(run_reverse),
    .ramp_set_sel(ramp_set_sel), .seq_running(seq_running),
    .drive_stop_req(drive_stop_req));

  setpoint_loop_model far (.ref_clk(ref_clk), .rst_n(rst_n), .freq_setpoint(freq),
    .run_reverse(run_reverse), .ramp_set_sel(ramp_set_sel),
    .drive_stop_req(drive_stop_req));

  // free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // handshakes judged as they stand at each rising edge; ready to the answer stays high
  // so a following call never lowers and raises it in one step; the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = seq_pkg::RESP_OKAY);
    logic tb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      tb = bvalid;
      r = bresp;
    end while (tb !== 1'b1);
    chk($sformatf("bresp at %h", a), {30'h0, er}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = seq_pkg::RESP_OKAY);
    logic tr;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      tr = rvalid;
      d = rdata;
      r = rresp;
    end while (tr !== 1'b1);
    chk($sformatf("rdata at %h", a), exp, d);
    chk($sformatf("rresp at %h", a), {30'h0, er}, {30'h0, r});
  endtask : rd

  // control word always carries the sequencer enable
  task automatic setc(input logic [15:0] bits);
    wr(seq_pkg::CTRL_OFS, {16'h0, bits | 16'h2000});
  endtask : setc

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic go();
    run_cmd <= 1'b1;
    tick(1);
    run_cmd <= 1'b0;
  endtask : go

  task automatic halt();
    stop_cmd <= 1'b1;
    tick(1);
    stop_cmd <= 1'b0;
    tick(5);
  endtask : halt

  // step value: odd steps negative so direction flips every step
  function automatic logic signed [15:0] v(input int i);
    return (i % 2) ? 16'(-(20 * i + 10)) : 16'(20 * i + 10);
  endfunction : v

  // interrupt a long step 5 by stop or supply loss, then see where it carries on
  task automatic retain(input logic pwr, input logic keep);
    setc(16'h0002 | (16'(keep) << (pwr ? 4 : 5)));
    go();
    tick(60);
    if (pwr) begin
      power_fail <= 1'b1;
      tick(20);
      power_fail <= 1'b0;
    end else begin
      halt();
    end
    base = far.seen_f.size();
    if (!pwr) go();
    tick(10);
    if (keep) chk("resumed setpoint", v(5), freq);
    else chk("restarted setpoint", v(0), far.seen_f[base]);
    halt();
  endtask : retain

  // hang guard: the whole sequence needs well under half of this span
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end

  initial begin
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    for (int i = 0; i < 32; i++) rd(8'(4 * i), 32'h0);
    rd(seq_pkg::CTRL_OFS, 32'h0);
    wr(8'h04, 32'h000007D0);
    rd(8'h04, 32'h000003E8);
    wr(8'h04, 32'h0000F830);
    rd(8'h04, 32'hFFFFFC18);
    wr(8'h7C, 32'h0003FFFF);
    rd(8'h7C, 32'h0003FFFF);
    wstrb <= 4'h1;
    wr(8'h7C, 32'h00000000);
    wstrb <= 4'hF;
    rd(8'h7C, 32'h0003FF00);
    wr(seq_pkg::CTRL_OFS, 32'hFFFFFFFF);
    rd(seq_pkg::CTRL_OFS, {16'h0, seq_pkg::CTRL_MASK});
    wr(seq_pkg::STAT_OFS, 32'h0, seq_pkg::RESP_SLVERR);
    rd(8'hFC, 32'h0, seq_pkg::RESP_SLVERR);
    // step 3 lasts 2 units and step 5 is long enough to be interrupted
    for (int i = 0; i < 16; i++) begin
      wr(8'(4 * i), {16'h0, v(i)});
      wr(8'(8'h40 + 4 * i), {14'h0, 2'(i), 16'(i == 3 ? 2 : i == 5 ? 50 : 0)});
    end
    // every source of reference zero, each input moved to a fresh value
    for (int k = 0; k < 7; k++) begin
      ai1 <= 16'(101 + k);
      ai2 <= 16'(202 + k);
      ai3 <= 16'(303 + k);
      pulse <= 16'(404 + k);
      pidin <= 16'(505 + k);
      preset <= 16'(606 + k);
      setc(16'(k << 8));
      tick(4);
      chk("source pick", k == 0 ? v(0) : 16'(101 * k + k), pid_sp);
    end
    setc(16'h0000);
    terms <= 4'h5;
    maxf <= 16'h07D0;
    tick(6);
    chk("freq scaled", 32'hFFFFFF24, freq);
    chk("volt scaled", 32'hFFFFFFC9, volt);
    chk("pid plain", v(5), pid_sp);
    terms <= 4'h1;
    maxf <= 16'h03E8;
    tick(6);
    base = far.seen_f.size();
    go();
    tick(240);
    for (int k = 0; k < 16; k++) begin
      chk("step value", v(k), far.seen_f[base + k]);
      chk("step reverse", 32'(v(k) < 0), 32'(far.seen_rev[base + k]));
      chk("step ramp", 32'(k % 4), 32'(far.seen_ramp[base + k]));
    end
    chk("step3 time", 9, 32'(far.seen_at[base + 4] - far.seen_at[base + 3]));
    chk("step1 time", 1, 32'(far.seen_at[base + 2] - far.seen_at[base + 1]));
    chk("after cycle", v(1), far.seen_f[base + 16]);
    chk("stop pulses", 1, 32'(far.stops));
    chk("stopped", 0, 32'(seq_running));
    setc(16'h0002);
    base = far.seen_f.size();
    go();
    tick(240);
    chk("second cycle", v(0), far.seen_f[base + 16]);
    chk("repeating", 1, 32'(seq_running));
    halt();
    chk("stop taken", 0, 32'(seq_running));
    setc(16'h0001);
    go();
    tick(240);
    chk("held freq", v(15), freq);
    chk("held reverse", 1, 32'(run_reverse));
    chk("held running", 1, 32'(seq_running));
    rd(seq_pkg::STAT_OFS, 32'h0000014F);
    halt();
    setc(16'h1001);
    go();
    tick(240);
    chk("voltage target", 32'hFFFFFF65, volt);
    chk("freq idle", 0, freq);
    halt();
    retain(1'b0, 1'b1);
    retain(1'b0, 1'b0);
    retain(1'b1, 1'b1);
    retain(1'b1, 1'b0);
    wr(8'h40, 32'h00000001);
    setc(16'h0004);
    base = far.seen_f.size();
    go();
    tick(14300);
    chk("hour step", v(0), freq);
    tick(200);
    chk("hour next", v(1), far.seen_f[base + 1]);
    halt();
    stop_test();
  end
endmodule : multi_reference_step_sequencer_test
